// >>> pls_pkg.sv
package pls_pkg;
   // ************************************************
   // array geometry
   // ************************************************
   localparam int unsigned ARRAY_DEPTH = 512;
   localparam int unsigned ADDR_W      = 9;
   localparam int unsigned PAGE_W      = 4;
   // ************************************************
   // opcodes
   // ************************************************
   localparam logic [7:0] OP_SET_WRITE_LATCH     = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_LATCH   = 8'h04;
   localparam logic [7:0] OP_SET_PARTITION_LOCK  = 8'h01;
   localparam logic [7:0] OP_READ_LOCK_STATUS    = 8'h05;
   localparam logic [7:0] OP_ARRAY_READ          = 8'h03;
   localparam logic [7:0] OP_ARRAY_WRITE         = 8'h02;
   // ************************************************
   // lock register
   // ************************************************
   localparam int unsigned LOCK_SEL_W   = 3;
   localparam logic [2:0]  LOCK_RESET   = 3'h0;
   localparam logic [2:0]  LOCK_NONE    = 3'h0;
   localparam logic [2:0]  LOCK_Q0      = 3'h1;
   localparam logic [2:0]  LOCK_Q1      = 3'h2;
   localparam logic [2:0]  LOCK_Q2      = 3'h3;
   localparam logic [2:0]  LOCK_Q3      = 3'h4;
   localparam logic [2:0]  LOCK_LOW_HALF = 3'h5;
   localparam logic [2:0]  LOCK_FIRST_PG = 3'h6;
   localparam logic [2:0]  LOCK_LAST_PG  = 3'h7;
   // ************************************************
   // timing
   // ************************************************
   localparam int unsigned CLK_NS          = 10;
   localparam int unsigned NV_WRITE_NS     = 5000;
   localparam int unsigned NV_WRITE_CYCLES = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned NV_CNT_W        = 10;

   typedef enum logic [2:0] {
      PLS_OPCODE,
      PLS_ADDR,
      PLS_WDATA,
      PLS_RDATA,
      PLS_LOCKBYTE,
      PLS_STATUS,
      PLS_IGNORE
   } pls_state_t;
endpackage

// >>> pls_spi_sync.sv
`timescale 1ns/1ps
module pls_spi_sync (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic cs_n_pin_i,
   input  wire logic sck_pin_i,
   input  wire logic mosi_pin_i,
   output logic      cs_n_o,
   output logic      sck_rise_o,
   output logic      sck_fall_o,
   output logic      mosi_o
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic       sck_prev_q;

   // ************************************************
   // two-stage synchroniser, edges taken after stage two
   // ************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q     <= 3'h1;
         sync_q     <= 3'h1;
         sck_prev_q <= 1'b0;
      end else begin
         meta_q     <= {mosi_pin_i, sck_pin_i, cs_n_pin_i};
         sync_q     <= meta_q;
         sck_prev_q <= sync_q[1];
      end
   end

   assign cs_n_o     = sync_q[0];
   assign mosi_o     = sync_q[2];
   assign sck_rise_o = sync_q[1] & ~sck_prev_q & ~sync_q[0];
   assign sck_fall_o = ~sync_q[1] & sck_prev_q & ~sync_q[0];
endmodule

// >>> pls_partition_lock.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - array holds 512 bytes addressed by nine bits
// R2 - serial access always allowed except while sleep is asserted
// R3 - host waits power-up read and write delays before array access
// R4 - array writes rejected unless write latch already set
// R5 - set-latch opcode sets latch, clear-latch opcode clears it
// R6 - latch clears at reset and after each completed write cycle
// R7 - seven lockable regions, from one page to half the array
// R8 - lock sequence honoured only while write latch set
// R9 - host sends lock opcode then lock byte in one select period
// R10 - lock code map: 1-4 quarters, 5 low half, 6 first, 7 last page
// R11 - lock selection taken from lock byte bits 2 to 0
// R12 - host writes zeros into lock byte bits 7 to 3
// R13 - raising select after lock bytes starts nonvolatile lock write
// R14 - later lock bytes replace earlier ones, last one wins
// R15 - lock setting retained until next lock instruction; code also clears it to LOCK_RESET on reset
// R16 - locked addresses readable, writes blocked
// R17 - lock register eight bits, bits 7 to 3 read zero
// R18 - set-latch opcode is 00000110, msb first
// R19 - clear-latch opcode is 00000100, msb first
// R20 - lock opcode is 00000001 followed by lock byte
// R21 - lock status read returns lock byte when no write busy
// R22 - rejected writes leave array unchanged, no error shown
module pls_partition_lock (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic sleep_i,
   input  wire logic spi_cs_n_i,
   input  wire logic spi_sck_i,
   input  wire logic spi_mosi_i,
   output logic      spi_miso_o,
   output logic      spi_miso_oe_o,
   output logic      write_latch_o,
   output logic [7:0] partition_lock_o,
   output logic      nv_busy_o
);
   logic [1:0]                    rst_sync_q;
   logic                          rst_n;
   logic                          cs_n, sck_rise, sck_fall, mosi;
   pls_pkg::pls_state_t           state_q;
   logic [2:0]                    bit_q;
   logic [7:0]                    shift_q;
   logic [7:0]                    out_q;
   logic [15:0]                   addr_sh_q;
   logic                          addr_hi_q;
   logic [pls_pkg::ADDR_W-1:0]    addr_q;
   logic [7:0]                    mem_q [0:pls_pkg::ARRAY_DEPTH-1];
   logic [7:0]                    page_q [0:(1<<pls_pkg::PAGE_W)-1];
   logic [(1<<pls_pkg::PAGE_W)-1:0] page_v_q;
   logic [pls_pkg::ADDR_W-1:0]    page_base_q;
   logic                          wr_armed_q, wr_pend_q;
   logic [2:0]                    lock_q, lock_new_q;
   logic                          lock_armed_q, lock_pend_q;
   logic                          latch_q, cmd_wel_q;
   logic [pls_pkg::NV_CNT_W-1:0]  nv_cnt_q;
   logic                          nv_busy_q, nv_is_lock_q;
   logic                          cs_prev_q;
   logic                          miso_q, miso_oe_q;
   logic [7:0]                    byte_in;
   logic                          byte_done, cs_rise;

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic addr_locked(input logic [2:0] sel, input logic [8:0] a);
      case (sel) // R7 R10
         pls_pkg::LOCK_Q0:       addr_locked = (a[8:7] == 2'h0);
         pls_pkg::LOCK_Q1:       addr_locked = (a[8:7] == 2'h1);
         pls_pkg::LOCK_Q2:       addr_locked = (a[8:7] == 2'h2);
         pls_pkg::LOCK_Q3:       addr_locked = (a[8:7] == 2'h3);
         pls_pkg::LOCK_LOW_HALF: addr_locked = ~a[8];
         pls_pkg::LOCK_FIRST_PG: addr_locked = (a[8:4] == 5'h00);
         pls_pkg::LOCK_LAST_PG:  addr_locked = (a[8:4] == 5'h1F);
         default:                addr_locked = 1'b0;
      endcase
   endfunction

   // ************************************************
   // reset release and pin sync
   // ************************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   pls_spi_sync u_sync (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n),
      .cs_n_pin_i (spi_cs_n_i | sleep_i), // R2
      .sck_pin_i  (spi_sck_i),
      .mosi_pin_i (spi_mosi_i),
      .cs_n_o     (cs_n),
      .sck_rise_o (sck_rise),
      .sck_fall_o (sck_fall),
      .mosi_o     (mosi)
   );

   assign byte_in   = {shift_q[6:0], mosi};
   assign byte_done = sck_rise && (bit_q == 3'h7);
   assign cs_rise   = cs_n && !cs_prev_q;

   // ************************************************
   // serial command decoder
   // ************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q      <= pls_pkg::PLS_OPCODE;
         bit_q        <= 3'h0;
         shift_q      <= 8'h00;
         addr_sh_q    <= 16'h0000;
         addr_hi_q    <= 1'b0;
         addr_q       <= '0;
         page_v_q     <= '0;
         page_base_q  <= '0;
         wr_armed_q   <= 1'b0;
         lock_new_q   <= pls_pkg::LOCK_RESET;
         lock_armed_q <= 1'b0;
         cmd_wel_q    <= 1'b0;
         cs_prev_q    <= 1'b1;
         out_q        <= 8'h00;
      end else begin
         cs_prev_q <= cs_n;
         cmd_wel_q <= 1'b0;
         if (cs_n) begin
            state_q      <= pls_pkg::PLS_OPCODE;
            bit_q        <= 3'h0;
            wr_armed_q   <= 1'b0;
            lock_armed_q <= 1'b0;
            addr_hi_q    <= 1'b0;
            if (cs_rise && !wr_armed_q && !nv_busy_q) begin
               page_v_q <= '0;
            end
         end else if (sck_rise) begin
            bit_q   <= bit_q + 3'h1;
            shift_q <= byte_in;
            if (byte_done) begin
               wr_armed_q <= 1'b0; // abort unless cs rises right at a byte end
               case (state_q)
                  pls_pkg::PLS_OPCODE: begin
                     if (byte_in == pls_pkg::OP_SET_WRITE_LATCH || byte_in == pls_pkg::OP_CLEAR_WRITE_LATCH) begin
                        cmd_wel_q <= 1'b1; // R18 R19
                        state_q   <= pls_pkg::PLS_IGNORE;
                     end else if (byte_in == pls_pkg::OP_ARRAY_WRITE || byte_in == pls_pkg::OP_ARRAY_READ) begin
                        out_q     <= byte_in;
                        page_v_q  <= nv_busy_q ? page_v_q : '0; // pending page kept while busy
                        state_q   <= pls_pkg::PLS_ADDR;
                     end else if (byte_in == pls_pkg::OP_SET_PARTITION_LOCK) begin
                        state_q   <= pls_pkg::PLS_LOCKBYTE; // R20
                     end else if (byte_in == pls_pkg::OP_READ_LOCK_STATUS) begin
                        state_q   <= pls_pkg::PLS_STATUS; // R21
                     end else begin
                        state_q   <= pls_pkg::PLS_IGNORE;
                     end
                  end
                  pls_pkg::PLS_ADDR: begin
                     addr_sh_q <= {addr_sh_q[7:0], byte_in};
                     addr_hi_q <= 1'b1;
                     if (addr_hi_q) begin
                        addr_q      <= {addr_sh_q[0], byte_in}; // R1
                        page_base_q <= nv_busy_q ? page_base_q : {addr_sh_q[0], byte_in[7:4], 4'h0};
                        state_q     <= (out_q == pls_pkg::OP_ARRAY_WRITE) ? pls_pkg::PLS_WDATA
                                                                          : pls_pkg::PLS_RDATA;
                     end
                  end
                  pls_pkg::PLS_WDATA: begin
                     page_v_q[addr_q[3:0]] <= page_v_q[addr_q[3:0]] | !nv_busy_q;
                     addr_q[3:0]           <= addr_q[3:0] + 4'h1; // page roll-over
                     wr_armed_q            <= latch_q && !nv_busy_q; // R4
                  end
                  pls_pkg::PLS_RDATA: begin
                     addr_q <= addr_q + 9'h001; // full-array roll-over
                  end
                  pls_pkg::PLS_LOCKBYTE: begin
                     lock_new_q   <= nv_busy_q ? lock_new_q : byte_in[2:0]; // R11 R14
                     lock_armed_q <= latch_q && !nv_busy_q; // R8
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!cs_n && byte_done && state_q == pls_pkg::PLS_WDATA && !nv_busy_q) begin
         page_q[addr_q[3:0]] <= byte_in;
      end
   end

   // ************************************************
   // write latch
   // ************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= 1'b0; // R6
      end else if (nv_busy_q && nv_cnt_q == pls_pkg::NV_CNT_W'(1)) begin
         latch_q <= 1'b0; // R6
      end else if (cs_rise && cmd_wel_q == 1'b0 && state_q == pls_pkg::PLS_IGNORE && shift_q == pls_pkg::OP_SET_WRITE_LATCH && bit_q == 3'h0) begin
         latch_q <= 1'b1; // R5
      end else if (cs_rise && state_q == pls_pkg::PLS_IGNORE && shift_q == pls_pkg::OP_CLEAR_WRITE_LATCH && bit_q == 3'h0) begin
         latch_q <= 1'b0; // R5
      end
   end

   // ************************************************
   // nonvolatile write cycle
   // ************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         nv_cnt_q     <= '0;
         nv_busy_q    <= 1'b0;
         nv_is_lock_q <= 1'b0;
         lock_q       <= pls_pkg::LOCK_RESET;
      end else if (nv_busy_q) begin
         nv_cnt_q <= nv_cnt_q - pls_pkg::NV_CNT_W'(1);
         if (nv_cnt_q == pls_pkg::NV_CNT_W'(1)) begin
            nv_busy_q <= 1'b0;
            if (nv_is_lock_q) begin
               lock_q <= lock_new_q; // R15
            end
         end
      end else if (cs_rise && bit_q == 3'h0 && (wr_armed_q || lock_armed_q)) begin
         nv_busy_q    <= 1'b1; // R13
         nv_is_lock_q <= !wr_armed_q;
         nv_cnt_q     <= pls_pkg::NV_CNT_W'(pls_pkg::NV_WRITE_CYCLES);
      end
   end

   // locked bytes of the page are silently dropped
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < (1 << pls_pkg::PAGE_W); i++) begin
         if (nv_busy_q && !nv_is_lock_q && nv_cnt_q == pls_pkg::NV_CNT_W'(1) && page_v_q[i]
             && !addr_locked(lock_q, page_base_q | pls_pkg::ADDR_W'(i))) begin
            mem_q[page_base_q | pls_pkg::ADDR_W'(i)] <= page_q[i]; // R16 R22
         end
      end
   end

   // ************************************************
   // serial output, changes on falling sck
   // ************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         miso_q    <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_oe_q <= !cs_n;
         if (cs_n) begin
            miso_q <= 1'b0;
         end else if (sck_fall) begin
            if (state_q == pls_pkg::PLS_STATUS) begin
               miso_q <= nv_busy_q | partition_lock_o[3'h7 - bit_q]; // R17 R21
            end else if (state_q == pls_pkg::PLS_RDATA) begin
               miso_q <= mem_q[addr_q][3'h7 - bit_q]; // R16
            end else begin
               miso_q <= 1'b0;
            end
         end
      end
   end

   assign spi_miso_o       = miso_q;
   assign spi_miso_oe_o    = miso_oe_q;
   assign write_latch_o    = latch_q;
   assign partition_lock_o = {5'h00, lock_q}; // R17
   assign nv_busy_o        = nv_busy_q;

   // ************************************************
   // checks
   // ************************************************
   a_lock_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n) partition_lock_o[7:3] == 5'h00)  // R17
      else $error("lock register upper bits not zero");
   a_latch_clears_done: assert property (@(posedge clk_i) disable iff (!rst_n)
      $fell(nv_busy_q) |-> !latch_q)  // R6
      else $error("write latch survived write cycle");
   a_lock_needs_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(nv_busy_q) |-> $past(latch_q))  // R8
      else $error("nonvolatile write started without latch");
   a_lock_stable_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
      !nv_busy_q |=> $stable(lock_q))  // R15
      else $error("lock changed outside write cycle");
   a_nv_cycle_len: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(nv_busy_q) |-> nv_cnt_q == pls_pkg::NV_CNT_W'(pls_pkg::NV_WRITE_CYCLES))  // R13
      else $error("write cycle length wrong");
   a_status_busy_high: assert property (@(posedge clk_i) disable iff (!rst_n)
      (sck_fall && !cs_n && state_q == pls_pkg::PLS_STATUS && nv_busy_q) |=> miso_q)  // R21
      else $error("busy not shown on status read");
   a_wr_needs_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(wr_armed_q) |-> $past(latch_q))  // R4
      else $error("write armed without latch");
   a_sleep_blocks: assert property (@(posedge clk_i) disable iff (!rst_n)
      sleep_i [*3] |-> cs_n)  // R2
      else $error("port active during sleep");
endmodule

// >>> pls_host_model.sv
`timescale 1ns/1ps
// ****************************************
// serial host, mode 0, msb first
// ****************************************
module pls_host_model #(
   parameter int HALF = 6
) (
   input  wire logic clk_i,
   input  wire logic miso_i,
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      mosi_o
);
   initial begin
      cs_n_o = 1'b1;
      sck_o  = 1'b0;
      mosi_o = 1'b0;
   end

   // one whole frame per call; sck stays low outside frames
   task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] r;
      rx = {};
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (HALF) @(posedge clk_i);
      foreach (tx[i]) begin
         for (int b = 7; b >= 0; b--) begin
            mosi_o <= tx[i][b];
            repeat (HALF) @(posedge clk_i);
            r[b] = miso_i;
            sck_o <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            sck_o <= 1'b0;
         end
         rx.push_back(r);
      end
      repeat (HALF) @(posedge clk_i);
      cs_n_o <= 1'b1;
      // released line must not keep its last level
      mosi_o <= ~mosi_o;
      repeat (2 * HALF) @(posedge clk_i);
   endtask
endmodule

// >>> pls_partition_lock_tb.sv
`timescale 1ns/1ps
module pls_partition_lock_tb;
   localparam int LIMIT = 90000;
   logic       clk_i;
   logic       rstn_i;
   logic       sleep_i;
   logic       cs_n;
   logic       sck;
   logic       mosi;
   logic       miso;
   logic       miso_oe;
   logic       latch;
   logic       busy;
   logic [7:0] lock;
   int         error_cnt = 0;
   int         total_checks = 0;
   int         cycles = 0;
   logic [7:0] exp_mem [512];
   logic [2:0] cur_lock = 3'h0;
   logic [7:0] rx [$];
   // probe pairs 1 to 7: locked address at a region edge and its neighbour outside; pair 0 spans both array ends
   logic [8:0] in_a [8] = '{9'h000, 9'h07F, 9'h080, 9'h17F, 9'h180, 9'h0FF, 9'h00F, 9'h1F0};
   logic [8:0] out_a [8] = '{9'h1FF, 9'h080, 9'h07F, 9'h180, 9'h17F, 9'h100, 9'h010, 9'h1EF};

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   pls_partition_lock dut (
      .clk_i            (clk_i),
      .rstn_i           (rstn_i),
      .sleep_i          (sleep_i),
      .spi_cs_n_i       (cs_n),
      .spi_sck_i        (sck),
      .spi_mosi_i       (mosi),
      .spi_miso_o       (miso),
      .spi_miso_oe_o    (miso_oe),
      .write_latch_o    (latch),
      .partition_lock_o (lock),
      .nv_busy_o        (busy)
   );

   pls_host_model host (
      .clk_i  (clk_i),
      .miso_i (miso),
      .cs_n_o (cs_n),
      .sck_o  (sck),
      .mosi_o (mosi)
   );

   // ****************************************
   // checks and bus tasks
   // ****************************************
   function automatic bit is_locked(input logic [8:0] a, input logic [2:0] c);
      case (c)
         3'h1: return a < 9'h080;
         3'h2: return a >= 9'h080 && a < 9'h100;
         3'h3: return a >= 9'h100 && a < 9'h180;
         3'h4: return a >= 9'h180;
         3'h5: return a < 9'h100;
         3'h6: return a < 9'h010;
         3'h7: return a >= 9'h1F0;
         default: return 1'b0;
      endcase
   endfunction

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // bounded wait for the nonvolatile cycle to end
   task automatic wait_nv(input bit chk, input logic want);
      int n;
      n = 0;
      repeat (10) @(posedge clk_i);
      if (chk) check_bit(busy, want);
      while (busy !== 1'b0 && n < 700) begin
         @(posedge clk_i);
         n++;
      end
      check_bit(busy, 1'b0);
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic en);
      logic ok;
      ok = en && !is_locked(a, cur_lock);
      host.xfer({en ? pls_pkg::OP_SET_WRITE_LATCH : pls_pkg::OP_CLEAR_WRITE_LATCH}, rx);
      check_bit(latch, en);
      host.xfer({pls_pkg::OP_ARRAY_WRITE, 8'(a[8]), a[7:0], d}, rx);
      wait_nv(ok || !en, ok);
      if (ok) check_bit(latch, 1'b0);
      if (ok) exp_mem[a] = d;
   endtask

   task automatic rd(input logic [8:0] a);
      fork
         host.xfer({pls_pkg::OP_ARRAY_READ, 8'(a[8]), a[7:0], 8'h00}, rx);
         begin
            repeat (20) @(posedge clk_i);
            check_bit(miso_oe, 1'b1);
         end
      join
      check_byte(rx[3], exp_mem[a]);
   endtask

   task automatic set_lock(input logic [2:0] c);
      logic [2:0] nc;
      nc = ~c;
      host.xfer({pls_pkg::OP_SET_WRITE_LATCH}, rx);
      host.xfer({pls_pkg::OP_SET_PARTITION_LOCK, 8'(nc), 8'(c)}, rx);
      host.xfer({pls_pkg::OP_READ_LOCK_STATUS, 8'h00}, rx);
      check_byte(rx[1], 8'hFF);
      wait_nv(1'b1, 1'b1);
      check_byte(lock, 8'(c));
      host.xfer({pls_pkg::OP_READ_LOCK_STATUS, 8'h00}, rx);
      check_byte(rx[1], 8'(c));
      check_bit(latch, 1'b0);
      cur_lock = c;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         stop_test();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rstn_i = 1'b0;
      sleep_i = 1'b0;
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      check_bit(latch, 1'b0);
      check_byte(lock, 8'h00);
      check_bit(busy, 1'b0);
      sleep_i <= 1'b1;
      fork
         host.xfer({pls_pkg::OP_SET_WRITE_LATCH}, rx);
         begin
            repeat (20) @(posedge clk_i);
            check_bit(miso_oe, 1'b0);
         end
      join
      check_bit(latch, 1'b0);
      sleep_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int c = 0; c < 8; c++) begin
         wr(in_a[c], 8'hA0 | 8'(c), 1'b1);
         wr(out_a[c], 8'h50 | 8'(c), 1'b1);
      end
      wr(9'h000, 8'h33, 1'b0);
      rd(9'h000);
      for (int c = 1; c < 8; c++) begin
         set_lock(3'(c));
         wr(in_a[c], 8'hC0 | 8'(c), 1'b1);
         wr(out_a[c], 8'h30 | 8'(c), 1'b1);
         rd(in_a[c]);
         rd(out_a[c]);
      end
      host.xfer({pls_pkg::OP_CLEAR_WRITE_LATCH}, rx);
      host.xfer({pls_pkg::OP_SET_PARTITION_LOCK, 8'h03}, rx);
      wait_nv(1'b1, 1'b0);
      check_byte(lock, 8'h07);
      set_lock(3'h0);
      wr(in_a[7], 8'h99, 1'b1);
      rd(in_a[7]);
      stop_test();
   end
endmodule
